//--- core/pipe_core.sv
// decoupled fetch and two-pass execute pipeline with its instruction queue
`default_nettype none

module pipe_core (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   output logic                             ibus_req,
   output logic      [pipe_pkg::WORD_W-1:0] ibus_addr,
   input  wire logic                        ibus_gnt,
   input  wire logic                        ibus_rvalid,
   input  wire logic [pipe_pkg::WORD_W-1:0] ibus_rdata,
   output logic                             dbus_req,
   output pipe_pkg::dbus_cmd_t              dbus_cmd,
   input  wire logic                        dbus_gnt,
   input  wire logic                        dbus_rvalid,
   input  wire logic [pipe_pkg::WORD_W-1:0] dbus_rdata,
   output logic                             retire
);
   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [31:0]         pc_ff;
   logic [31:0]         nxt_pc;
   logic [1:0]          out_ff;
   logic                ibus_fire;
   logic                q_push;
   logic                q_pop;
   logic [31:0]         q_head;
   logic                q_empty;
   logic                q_full;
   logic [1:0]          q_count;
   logic                src_vld;
   logic [31:0]         src_instr;
   pipe_pkg::stage_t    dec_ff;
   logic                dec_vld_ff;
   pipe_pkg::stage_t    ex_ff;
   logic                ex_vld_ff;
   pipe_pkg::stage_t    to_ex;
   pipe_pkg::dec_t      dd;
   pipe_pkg::dec_t      xd;
   logic [31:0]         rf_ff [pipe_pkg::NREG];
   logic [31:0]         sum;
   logic                ex_bus;
   logic                ex_done;
   logic                ex_free;
   logic                ex_first;
   logic                dec_ready;
   logic                dec_move;
   logic                dec_first_two;
   logic                hold_new;
   logic                recirc;
   logic                dec_accept;
   logic                dec_load;
   logic                wb_en;
   logic [2:0]          wb_idx;
   logic                dbus_req_ff;
   pipe_pkg::dbus_cmd_t cmd_ff;
   pipe_pkg::dbus_cmd_t nxt_cmd;
   logic                retire_ff;

   // register read with forwarding from the write in the same cycle
   function automatic logic [31:0] rd_reg(input logic [2:0] idx);
      rd_reg = (wb_en && (wb_idx == idx)) ? sum : rf_ff[idx];
   endfunction : rd_reg

   ////////////////////////////////////////////////////////////////////////////
   // fetch_addr_gen_stage and fetch_cycle_stage
   // credit counts queue entries plus prefetches in flight, so every answer
   // has a slot even if execute stalls; costs one slot of lookahead on bypass
   assign ibus_req  = ({1'b0, q_count} + {1'b0, out_ff}) <
                      3'(pipe_pkg::QDEPTH);
   assign ibus_addr = pc_ff;
   assign ibus_fire = ibus_req && ibus_gnt;

   always_comb begin
      nxt_pc = pc_ff;
      if (ibus_fire) begin
         nxt_pc = pc_ff + pipe_pkg::PC_STEP;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_ff <= pipe_pkg::RESET_PC;
      end else begin
         pc_ff <= nxt_pc;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         out_ff <= 2'h0;
      end else if (ibus_fire && !ibus_rvalid) begin
         out_ff <= out_ff + 2'h1;
      end else if (!ibus_fire && ibus_rvalid) begin
         out_ff <= out_ff - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instr_queue_stage
   assign src_vld   = !q_empty || ibus_rvalid;
   assign src_instr = q_empty ? ibus_rdata : q_head;
   assign q_push    = ibus_rvalid && !(q_empty && dec_accept);
   assign q_pop     = dec_accept && !q_empty;
   assign dec_load  = dec_accept && src_vld;

   instr_queue u_queue (
      .clk       (clk),
      .rstn      (rstn),
      .push      (q_push),
      .push_data (ibus_rdata),
      .pop       (q_pop),
      .head_data (q_head),
      .empty     (q_empty),
      .full      (q_full),
      .count     (q_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decode_operand_stage
   op_decode u_dec_decode (
      .instr (dec_ff.instr),
      .dec   (dd)
   );

   // a second pass waits here for the operand read to come back
   assign dec_ready = dec_vld_ff && ((dec_ff.pass != pipe_pkg::PASS_TWO) || dbus_rvalid);
   assign dec_move  = dec_ready && ex_free;
   assign dec_first_two = dd.two_pass && (dec_ff.pass == pipe_pkg::PASS_ONE);
   assign ex_first  = ex_vld_ff && xd.two_pass && (ex_ff.pass == pipe_pkg::PASS_ONE);
   // keep the decode slot free for the returning second pass
   assign hold_new  = ex_first || (dec_move && dec_first_two);
   assign dec_accept = (!dec_vld_ff || dec_move) && !hold_new && !recirc;

   always_comb begin
      to_ex = dec_ff;
      if (dec_ff.pass == pipe_pkg::PASS_TWO) begin
         to_ex.a = dbus_rdata;
         to_ex.b = (dd.cls == pipe_pkg::CLS_RMW) ? rd_reg(dd.rd) : 32'h0000_0000;
         to_ex.c = dec_ff.c;
      end else if (dd.cls == pipe_pkg::CLS_RR) begin
         to_ex.a = rd_reg(dd.rd);
         to_ex.b = rd_reg(dd.rs);
         to_ex.c = 32'h0000_0000;
      end else begin
         to_ex.a = rd_reg(dd.rs);
         to_ex.b = dd.imm;
         to_ex.c = rd_reg(dd.rd);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dec_vld_ff <= 1'b0;
         dec_ff     <= '0;
      end else if (recirc) begin
         dec_vld_ff   <= 1'b1;
         dec_ff       <= ex_ff;
         dec_ff.pass  <= pipe_pkg::PASS_TWO;
         dec_ff.c     <= sum;
      end else if (dec_load) begin
         dec_vld_ff   <= 1'b1;
         dec_ff       <= '0;
         dec_ff.instr <= src_instr;
         dec_ff.pass  <= pipe_pkg::PASS_ONE;
      end else if (dec_move) begin
         dec_vld_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // addr_exec_stage
   op_decode u_ex_decode (
      .instr (ex_ff.instr),
      .dec   (xd)
   );

   assign sum     = ex_ff.a + ex_ff.b;
   assign ex_bus  = xd.uses_bus &&
                    !((xd.cls == pipe_pkg::CLS_LD) && (ex_ff.pass == pipe_pkg::PASS_TWO));
   // one bus command in flight; the stage waits until the last is granted
   assign ex_done = ex_vld_ff && (!ex_bus || !dbus_req_ff);
   assign ex_free = !ex_vld_ff || ex_done;
   assign recirc  = ex_done && ex_first;
   assign wb_en   = ex_done && ((xd.cls == pipe_pkg::CLS_RR) ||
                    ((xd.cls == pipe_pkg::CLS_LD) && (ex_ff.pass == pipe_pkg::PASS_TWO)));
   assign wb_idx  = xd.rd;

   always_comb begin
      nxt_cmd       = '0;
      nxt_cmd.we    = !ex_first;
      nxt_cmd.addr  = sum;
      nxt_cmd.wdata = ex_ff.c;
      if ((xd.cls == pipe_pkg::CLS_RMW) && (ex_ff.pass == pipe_pkg::PASS_TWO)) begin
         nxt_cmd.addr  = ex_ff.c;
         nxt_cmd.wdata = sum;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ex_vld_ff <= 1'b0;
         ex_ff     <= '0;
      end else if (dec_move) begin
         ex_vld_ff <= 1'b1;
         ex_ff     <= to_ex;
      end else if (ex_done) begin
         ex_vld_ff <= 1'b0;
      end
   end

   for (genvar r = 0; r < pipe_pkg::NREG; r++) begin : g_reg
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rf_ff[r] <= 32'h0000_0000;
         end else if (wb_en && (wb_idx == 3'(r))) begin
            rf_ff[r] <= sum;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dbus_req_ff <= 1'b0;
         cmd_ff      <= '0;
      end else if (ex_done && ex_bus) begin
         dbus_req_ff <= 1'b1;
         cmd_ff      <= nxt_cmd;
      end else if (dbus_gnt) begin
         dbus_req_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         retire_ff <= 1'b0;
      end else begin
         retire_ff <= ex_done && !recirc;
      end
   end

   assign dbus_req = dbus_req_ff;
   assign dbus_cmd = cmd_ff;
   assign retire   = retire_ff;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_ADDR_STEP: assert property (
      ibus_fire |=> ibus_addr == $past(ibus_addr) + pipe_pkg::PC_STEP)
      else $error("prefetch address did not step by one longword");

   AST_ADDR_HOLD: assert property (
      ibus_req && !ibus_gnt |=> ibus_addr == $past(ibus_addr))
      else $error("prefetch address moved without a grant");

   AST_PREFETCH_AHEAD: assert property (
      (({1'b0, q_count} + {1'b0, out_ff}) < 3'(pipe_pkg::QDEPTH)) |-> ibus_req)
      else $error("fetch idle while queue room remains");

   AST_NO_OVERRUN: assert property (
      q_full |-> !ibus_req)
      else $error("prefetch issued with the queue full");

   AST_BYPASS: assert property (
      ibus_rvalid && q_empty && dec_accept |=>
      dec_vld_ff && (dec_ff.instr == $past(ibus_rdata)) && q_empty)
      else $error("opcode did not bypass an empty queue");

   AST_ENQUEUE: assert property (
      ibus_rvalid && !q_empty && !q_pop |=> q_count == $past(q_count) + 2'h1)
      else $error("fetched opcode not held in the queue");

   AST_CAPACITY: assert property (
      q_push |-> !q_full)
      else $error("queue written beyond three longwords");

   AST_DECODE_TO_EXEC: assert property (
      dec_move |=> ex_vld_ff && (ex_ff.instr == $past(dec_ff.instr)))
      else $error("decoded instruction did not reach the second stage");

   AST_ONE_PASS: assert property (
      ex_done && (xd.cls == pipe_pkg::CLS_ST) |=>
      dbus_req && dbus_cmd.we && !(dec_vld_ff && dec_ff.pass == pipe_pkg::PASS_TWO))
      else $error("store did not finish in a single pass");

   AST_TWO_PASS: assert property (
      recirc |=> dec_vld_ff && (dec_ff.pass == pipe_pkg::PASS_TWO) &&
      dbus_req && !dbus_cmd.we && (dbus_cmd.addr == dec_ff.c))
      else $error("memory operand did not start its second pass");

   AST_EXEC_SUM: assert property (
      wb_en |=> rf_ff[$past(wb_idx)] == $past(ex_ff.a) + $past(ex_ff.b))
      else $error("execute result not written back");

   COV_BYPASS: cover property (ibus_rvalid && q_empty && dec_accept);
   COV_QUEUE_FULL: cover property (q_full);
   COV_LOAD_RECIRC: cover property (recirc && (xd.cls == pipe_pkg::CLS_LD));
   COV_RMW_WRITE: cover property (dbus_req && dbus_cmd.we && dec_vld_ff ##1 retire);
endmodule : pipe_core

`default_nettype wire

//--- include/pipe_pkg.sv
// shared types and constants for the decoupled fetch/execute core pipeline
// Contract
// - fetch address stage forms the next prefetch address every cycle.
// - fetch cycle stage issues every prefetch as an instruction bus transfer.
// - a fifo instruction queue sits between fetch and execute to hide latency.
// - fetch keeps prefetching ahead of execute while queue room remains.
// - first execute stage decodes and fetches address parts or the operand.
// - second execute stage computes the operand address or executes.
// - with the queue empty, fetched opcodes go straight into execute; here only if the first execute stage accepts, else they are queued.
// - with the queue not empty, fetched opcodes are queued until taken.
// - the queue holds exactly three 32-bit longwords.
// - register and store instructions pass the execute stages once.
// - loads and read-modify-writes pass twice: address+read, then complete.
`default_nettype none

package pipe_pkg;
   localparam int          WORD_W   = 32;
   localparam int          QDEPTH   = 3;
   localparam int          QPTR_W   = 2;
   localparam int          NREG     = 8;
   localparam int          RIDX_W   = 3;
   localparam int          CLS_LSB  = 30;
   localparam int          RD_LSB   = 27;
   localparam int          RS_LSB   = 24;
   localparam int          IMM_LSB  = 0;
   localparam int          IMM_W    = 16;
   localparam logic [31:0] RESET_PC = 32'h0000_0000;
   localparam logic [31:0] PC_STEP  = 32'h0000_0004;

   typedef enum logic [1:0] {
      CLS_RR  = 2'h0,
      CLS_ST  = 2'h1,
      CLS_LD  = 2'h2,
      CLS_RMW = 2'h3
   } cls_t;

   typedef enum logic [1:0] {
      PASS_ONE = 2'h1,
      PASS_TWO = 2'h2
   } pass_t;

   typedef struct packed {
      cls_t              cls;
      logic [RIDX_W-1:0] rd;
      logic [RIDX_W-1:0] rs;
      logic [WORD_W-1:0] imm;
      logic              two_pass;
      logic              uses_bus;
   } dec_t;

   typedef struct packed {
      logic              we;
      logic [WORD_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } dbus_cmd_t;

   typedef struct packed {
      logic [WORD_W-1:0] instr;
      pass_t             pass;
      logic [WORD_W-1:0] a;
      logic [WORD_W-1:0] b;
      logic [WORD_W-1:0] c;
   } stage_t;
endpackage : pipe_pkg

`default_nettype wire

//--- core/op_decode.sv
// instruction field decoder shared by both execute stages
`default_nettype none

module op_decode (
   input  wire logic [pipe_pkg::WORD_W-1:0] instr,
   output var  pipe_pkg::dec_t              dec
);
   always_comb begin
      dec          = '0;
      dec.cls      = pipe_pkg::cls_t'(instr[pipe_pkg::CLS_LSB +: 2]);
      dec.rd       = instr[pipe_pkg::RD_LSB +: pipe_pkg::RIDX_W];
      dec.rs       = instr[pipe_pkg::RS_LSB +: pipe_pkg::RIDX_W];
      dec.imm      = {16'h0000, instr[pipe_pkg::IMM_LSB +: pipe_pkg::IMM_W]};
      dec.two_pass = (dec.cls == pipe_pkg::CLS_LD) || (dec.cls == pipe_pkg::CLS_RMW);
      dec.uses_bus = (dec.cls != pipe_pkg::CLS_RR);
   end
endmodule : op_decode

`default_nettype wire

//--- core/instr_queue.sv
// three-longword instruction fifo between fetch and execute
`default_nettype none

module instr_queue (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        push,
   input  wire logic [pipe_pkg::WORD_W-1:0] push_data,
   input  wire logic                        pop,
   output logic      [pipe_pkg::WORD_W-1:0] head_data,
   output logic                             empty,
   output logic                             full,
   output logic      [pipe_pkg::QPTR_W-1:0] count
);
   localparam logic [1:0] LAST = 2'(pipe_pkg::QDEPTH - 1);

   logic [pipe_pkg::WORD_W-1:0] mem_ff [pipe_pkg::QDEPTH];
   logic [1:0]                  wr_ptr_ff;
   logic [1:0]                  rd_ptr_ff;
   logic [1:0]                  count_ff;
   logic                        do_push;
   logic                        do_pop;

   assign empty   = (count_ff == 2'h0);
   assign full    = (count_ff == 2'(pipe_pkg::QDEPTH));
   assign count   = count_ff;
   // a push into a full queue is dropped so queued opcodes survive
   assign do_push = push && !full;
   assign do_pop  = pop && !empty;
   assign head_data = mem_ff[rd_ptr_ff];

   for (genvar g = 0; g < pipe_pkg::QDEPTH; g++) begin : g_entry
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            mem_ff[g] <= '0;
         end else if (do_push && (wr_ptr_ff == 2'(g))) begin
            mem_ff[g] <= push_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= 2'h0;
         rd_ptr_ff <= 2'h0;
      end else begin
         if (do_push) wr_ptr_ff <= (wr_ptr_ff == LAST) ? 2'h0 : wr_ptr_ff + 2'h1;
         if (do_pop)  rd_ptr_ff <= (rd_ptr_ff == LAST) ? 2'h0 : rd_ptr_ff + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= 2'h0;
      end else if (do_push && !do_pop) begin
         count_ff <= count_ff + 2'h1;
      end else if (do_pop && !do_push) begin
         count_ff <= count_ff - 2'h1;
      end
   end
endmodule : instr_queue

`default_nettype wire

//--- test/mem_model.sv
// behavioural program and data memory answering the core's two local buses
`default_nettype none

module mem_model (
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        slow,
   input  wire logic                        ibus_req,
   input  wire logic [pipe_pkg::WORD_W-1:0] ibus_addr,
   output logic                             ibus_gnt,
   output logic                             ibus_rvalid,
   output logic      [pipe_pkg::WORD_W-1:0] ibus_rdata,
   input  wire logic                        dbus_req,
   input  wire pipe_pkg::dbus_cmd_t         dbus_cmd,
   output logic                             dbus_gnt,
   output logic                             dbus_rvalid,
   output logic      [pipe_pkg::WORD_W-1:0] dbus_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] imem [0:1023];
   logic [31:0] dmem [0:63];
   logic [31:0] iq   [$];
   logic [31:0] dval;
   logic        dpend;
   int          pseed = 32'h5F5A8E69;
   int          idly;
   int          ddly;
   int          nrd;
   int          nwr;

   // slow mode stretches answers far enough to use up all prefetch credit
   function automatic int lat();
      return slow ? {$random(pseed)} % 8 : 0;
   endfunction : lat

   ////////////////////////////////////////////////////////////////////////////////
   // answers come in grant order; idle data lines carry noise, never the last word
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         iq.delete();
         idly = 0;
         ddly = 0;
         dpend = 1'b0;
         nrd = 0;
         nwr = 0;
         ibus_gnt <= 1'b0;
         ibus_rvalid <= 1'b0;
         ibus_rdata <= 32'h0;
         dbus_gnt <= 1'b0;
         dbus_rvalid <= 1'b0;
         dbus_rdata <= 32'h0;
      end else begin
         if (ibus_req && ibus_gnt) begin
            iq.push_back(ibus_addr);
         end
         if (idly == 0 && iq.size() > 0) begin
            ibus_rvalid <= 1'b1;
            ibus_rdata <= imem[iq[0][11:2]];
            void'(iq.pop_front());
            idly = lat();
         end else begin
            ibus_rvalid <= 1'b0;
            ibus_rdata <= $random(pseed);
            if (idly > 0) idly--;
         end
         if (dbus_req && dbus_gnt) begin
            if (dbus_cmd.we) begin
               dmem[dbus_cmd.addr[7:2]] = dbus_cmd.wdata;
               nwr++;
            end else begin
               dpend = 1'b1;
               dval = dmem[dbus_cmd.addr[7:2]];
               ddly = lat();
               nrd++;
            end
         end
         if (dpend && ddly == 0) begin
            dbus_rvalid <= 1'b1;
            dbus_rdata <= dval;
            dpend = 1'b0;
         end else begin
            dbus_rvalid <= 1'b0;
            dbus_rdata <= $random(pseed);
            if (ddly > 0) ddly--;
         end
         ibus_gnt <= (lat() < 4);
         dbus_gnt <= (lat() < 4);
      end
   end
endmodule : mem_model

`default_nettype wire

//--- test/pipe_core_tb_top.sv
// self-checking bench: random programs run with prompt and slow memory
`default_nettype none

module pipe_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NPROG = 48;
   localparam int LIMIT = 20000;
   logic                clk = 1'b0;
   logic                rstn = 1'b0;
   logic                slow = 1'b0;
   logic                ibus_req;
   logic [31:0]         ibus_addr;
   logic                ibus_gnt;
   logic                ibus_rvalid;
   logic [31:0]         ibus_rdata;
   logic                dbus_req;
   pipe_pkg::dbus_cmd_t dbus_cmd;
   logic                dbus_gnt;
   logic                dbus_rvalid;
   logic [31:0]         dbus_rdata;
   logic                retire;
   logic [31:0]         exp_pc;
   logic [31:0]         prog    [0:NPROG-1];
   logic [31:0]         ref_mem [0:63];
   int                  seed = 32'h5F5A8E69;
   int                  err_count = 0;
   int                  checks = 0;
   int                  cyc = 0;
   int                  outs;
   int                  max_out;
   int                  retired;
   int                  rv_cyc;
   int                  exp_rd;
   int                  exp_wr;

   always #10 clk = ~clk;

   pipe_core dut (.clk(clk), .rstn(rstn), .ibus_req(ibus_req), .ibus_addr(ibus_addr),
      .ibus_gnt(ibus_gnt), .ibus_rvalid(ibus_rvalid), .ibus_rdata(ibus_rdata),
      .dbus_req(dbus_req), .dbus_cmd(dbus_cmd), .dbus_gnt(dbus_gnt),
      .dbus_rvalid(dbus_rvalid), .dbus_rdata(dbus_rdata), .retire(retire));

   mem_model mem (.clk(clk), .rstn(rstn), .slow(slow), .ibus_req(ibus_req),
      .ibus_addr(ibus_addr), .ibus_gnt(ibus_gnt), .ibus_rvalid(ibus_rvalid),
      .ibus_rdata(ibus_rdata), .dbus_req(dbus_req), .dbus_cmd(dbus_cmd),
      .dbus_gnt(dbus_gnt), .dbus_rvalid(dbus_rvalid), .dbus_rdata(dbus_rdata));

   task automatic fail(input string m);
      err_count++;
      $display("mismatch at %0t: %s", $time, m);
   endtask : fail

   task automatic end_sim();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////////////
   // reference: expected data memory and data bus traffic of the program
   function automatic void ref_run();
      logic [31:0] r [0:7];
      logic [31:0] w;
      logic [31:0] ea;
      foreach (r[i]) r[i] = 32'h0;
      exp_rd = 0;
      exp_wr = 0;
      for (int i = 0; i < NPROG; i++) begin
         w = prog[i];
         ea = r[w[26:24]] + {16'h0, w[15:0]};
         case (w[31:30])
            2'h0: r[w[29:27]] = r[w[29:27]] + r[w[26:24]];
            2'h1: begin
               ref_mem[ea[7:2]] = r[w[29:27]];
               exp_wr++;
            end
            2'h2: begin
               r[w[29:27]] = ref_mem[ea[7:2]];
               exp_rd++;
            end
            default: begin
               ref_mem[ea[7:2]] = ref_mem[ea[7:2]] + r[w[29:27]];
               exp_rd++;
               exp_wr++;
            end
         endcase
      end
   endfunction : ref_run

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         fail("timeout");
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus monitor; credit is judged on the state at the start of each cycle
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         outs = 0;
         max_out = 0;
         retired = 0;
         rv_cyc = -1;
         exp_pc = pipe_pkg::RESET_PC;
      end else begin
         checks++;
         if (outs >= pipe_pkg::QDEPTH && ibus_req !== 1'b0) begin
            fail("prefetch past credit");
         end
         if (ibus_req && ibus_gnt) begin
            checks++;
            if (ibus_addr !== exp_pc) fail("prefetch address out of sequence");
            exp_pc = exp_pc + pipe_pkg::PC_STEP;
            outs++;
         end
         if (ibus_rvalid) begin
            outs--;
            if (rv_cyc < 0) rv_cyc = cyc;
         end
         if (outs > max_out) max_out = outs;
         if (retire === 1'b1) begin
            if (retired == 0) begin
               checks++;
               if (cyc - rv_cyc != 3) fail("first opcode not bypassed");
            end
            retired++;
         end
      end
   end

   task automatic run_phase(input logic s);
      @(posedge clk);
      rstn <= 1'b0;
      slow <= s;
      @(negedge clk);
      checks++;
      if (ibus_addr !== pipe_pkg::RESET_PC || dbus_req !== 1'b0 ||
          retire !== 1'b0) begin
         fail("reset state");
      end
      for (int i = 0; i < 1024; i++) mem.imem[i] = (i < NPROG) ? $random(seed) : 32'h0;
      // corner: bypass on reg-reg, then load feeding an rmw and a store back to back
      mem.imem[0] = {2'h0, 3'h2, 3'h3, 24'h0};
      mem.imem[1] = {2'h2, 3'h1, 3'h0, 24'h8};
      mem.imem[2] = {2'h3, 3'h1, 3'h0, 24'h8};
      mem.imem[3] = {2'h1, 3'h1, 3'h0, 24'hC};
      for (int i = 0; i < 64; i++) begin
         mem.dmem[i] = $random(seed);
         ref_mem[i] = mem.dmem[i];
      end
      for (int i = 0; i < NPROG; i++) prog[i] = mem.imem[i];
      ref_run();
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      while (retired < NPROG) @(posedge clk);
      repeat (30) @(posedge clk);
      checks++;
      if (mem.nrd !== exp_rd) fail("operand read count");
      checks++;
      if (mem.nwr !== exp_wr) fail("operand write count");
      for (int i = 0; i < 64; i++) begin
         checks++;
         if (mem.dmem[i] !== ref_mem[i]) fail("data memory word differs");
      end
      if (s) begin
         checks++;
         if (max_out !== pipe_pkg::QDEPTH) fail("prefetch did not run ahead");
      end
   endtask : run_phase

   initial begin
      run_phase(1'b0);
      run_phase(1'b1);
      end_sim();
   end
endmodule : pipe_core_tb_top

`default_nettype wire
